// File: hw/flash_pin_regs.vh
`ifndef FLASH_PIN_REGS_VH
`define FLASH_PIN_REGS_VH
// Clock period of clk in nanoseconds.
`define CLK_NS 4
// Self-timed program and erase durations in microseconds.
`define T_PROG_US 3000
`define T_ERASE_US 4000
// Command opcodes.
`define OP_BUF_WR1 8'h10
`define OP_BUF_WR2 8'h11
`define OP_BUF_RD1 8'h20
`define OP_BUF_RD2 8'h21
`define OP_PROG1 8'h30
`define OP_PROG2 8'h31
`define OP_ERASE 8'h40
`define OP_STATUS 8'h50
`define OP_PROT_EN 8'h60
`define OP_FREEZE 8'h61
`define OP_GUARD_WR 8'h62
`define OP_BINARY 8'h70
// Byte counts within a frame: opcode is byte 0, address bytes 1 to 3.
`define BYTE_ADDR_LAST 3'h3
`define BYTE_DATA 3'h4
`define BYTE_GUARD_DONE 3'h5
`define BYTE_SAT 3'h7
`define BIT_LAST 3'h7
// Last byte index of a page in each page size (264 and 256 bytes).
`define PAGE_STD_LAST 9'h107
`define PAGE_BIN_LAST 9'h0ff
// Sector index bits within the 15-bit page number (1024 pages a sector).
`define SECT_HI 14
`define SECT_LO 10
`define SECTORS 32
// Status byte bit positions.
`define ST_READY 7
`define ST_WP_SEEN 6
`define ST_PROT_EN 5
`define ST_BINARY 4
`endif

// File: hw/flash_buf_ram.v
// Two page buffers held in one memory; the top address bit picks the buffer.
module flash_buf_ram #(
   parameter AW = 10,
   parameter DW = 8
) (
   // Clock and reset.
   input wire clk,
   input wire rst_b,
   // Write port.
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [DW-1:0] wr_data,
   // Read port, data registered.
   input wire rd_en,
   input wire [AW-1:0] rd_addr,
   output reg [DW-1:0] rd_data
);
   // Storage array, no reset so it maps onto RAM.
   reg [DW-1:0] mem [0:(1<<AW)-1];

   // Write on every enabled edge.
   always @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Read data come out of a register one edge after the request.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= {DW{1'b0}};
      end else if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule // flash_buf_ram

// File: hw/flash_pin_if.v
`include "flash_pin_regs.vh"

module flash_pin_if #(
   parameter PROG_CYCLES = (`T_PROG_US * 1000) / `CLK_NS,
   parameter ERASE_CYCLES = (`T_ERASE_US * 1000) / `CLK_NS,
   parameter TW = 24
) (
   // Clock and power-on reset.
   input wire clk,
   input wire rst_b,
   // Serial pins from the host.
   input wire select_n,
   input wire sclk,
   input wire sdi,
   output reg sdo,
   output reg sdo_oe,
   // Protection and reset pins.
   input wire write_protect_n,
   input wire reset_pin_n,
   // Array side: page data stream with back-pressure.
   output wire [7:0] arr_data,
   output wire arr_valid,
   input wire arr_ready,
   output reg [14:0] arr_page,
   output reg arr_prog_start,
   output reg arr_erase,
   // Device state.
   output wire busy,
   output wire standby
);
   // Cycle loads for the internal timer, cut to the timer width.
   localparam [31:0] PROG_W = PROG_CYCLES;
   localparam [31:0] ERASE_W = ERASE_CYCLES;
   localparam [TW-1:0] PROG_LD = PROG_W[TW-1:0];
   localparam [TW-1:0] ERASE_LD = ERASE_W[TW-1:0];

   // Next byte index inside a page, wrapping at the page end.
   function [8:0] ptr_inc;
      input [8:0] p;
      input bin;
      begin
         if (bin) begin
            ptr_inc = {1'b0, p[7:0] + 8'h01};
         end else if (p == `PAGE_STD_LAST) begin
            ptr_inc = 9'h000;
         end else begin
            ptr_inc = p + 9'h001;
         end
      end
   endfunction

   // True for the last byte index of a page.
   function is_last;
      input [8:0] p;
      input bin;
      begin
         is_last = bin ? (p == `PAGE_BIN_LAST) : (p == `PAGE_STD_LAST);
      end
   endfunction

   // Page number out of the 24-bit address.
   function [14:0] page_of;
      input [23:0] a;
      input bin;
      begin
         page_of = bin ? a[22:8] : a[23:9];
      end
   endfunction

   // Byte offset out of the 24-bit address.
   function [8:0] byte_of;
      input [23:0] a;
      input bin;
      begin
         byte_of = bin ? {1'b0, a[7:0]} : a[8:0];
      end
   endfunction

   // Two-flop synchronisers; the first stage feeds only the second.
   reg seln_s1, seln_s2, seln_s3;
   reg sck_s1, sck_s2, sck_s3;
   reg sdi_s1, sdi_s2;
   reg wp_s1, wp_s2;
   reg rpin_s1, rpin_s2;

   // Frame and shift state.
   reg framed_r;          // Frame opened by a select falling edge.
   reg [2:0] bit_r;       // Bit position within the current byte.
   reg [2:0] byte_r;      // Completed bytes, saturating.
   reg [6:0] sh_r;        // Bits gathered so far, oldest on top.
   reg [7:0] op_r;        // Opcode of the current frame.
   reg [23:0] addr_r;     // Address bytes of the current frame.
   reg [31:0] guard_sh_r; // Incoming guard register image.
   reg [8:0] ptr_r;       // Buffer byte pointer.
   reg rd_phase_r;        // Read data phase reached.
   reg ignore_r;          // Frame refused because the device is busy.
   reg [2:0] obit_r;      // Output bit position.
   reg [7:0] tx_r;        // Byte being shifted out.

   // Protection state.
   reg [31:0] guard_r;    // Sectors flagged for protection.
   reg [31:0] frozen_r;   // Sectors made read-only for good.
   reg prot_en_r;         // Software protection enabled.
   reg wp_seen_r;         // Protect pin has gone low since reset.
   reg bin_r;             // Binary 256-byte page size chosen.

   // Internal timed operation.
   reg [TW-1:0] timer_r;
   reg str_r;             // Streaming a buffer out to the array.
   reg str_buf_r;         // Buffer being streamed.
   reg [8:0] sidx_r;      // Next stream index.
   reg sdone_r;           // All stream reads issued.
   reg p1_r, p2_r;        // Read pipeline stages.

   // Memory ports.
   reg mwe_r, mre_r;
   reg [9:0] mwa_r, mra_r;
   reg [7:0] mwd_r;
   wire [7:0] mq;

   // Two-entry buffer towards the array.
   reg [7:0] f0_r, f1_r;
   reg [1:0] fcnt_r;

   // Input edges, seen on synchronised levels only.
   // either idle level works
   wire sck_rise = sck_s2 & ~sck_s3;
   wire sck_fall = ~sck_s2 & sck_s3;
   wire sel_fall = ~seln_s2 & seln_s3;
   wire sel_rise = seln_s2 & ~seln_s3;
   wire sel = ~seln_s2 & framed_r;
   wire [7:0] byte_in = {sh_r, sdi_s2};
   wire srst = ~rpin_s2;
   wire wp_low = ~wp_s2;

   // Opcode decode.
   wire is_wr = (op_r == `OP_BUF_WR1) | (op_r == `OP_BUF_WR2);
   wire is_rd = (op_r == `OP_BUF_RD1) | (op_r == `OP_BUF_RD2);
   wire is_prog = (op_r == `OP_PROG1) | (op_r == `OP_PROG2);
   wire op_buf = (op_r == `OP_BUF_WR2) | (op_r == `OP_BUF_RD2) | (op_r == `OP_PROG2);

   // Sector of the framed address and whether it is guarded.
   wire [14:0] fpage = page_of(addr_r, bin_r);
   wire [4:0] fsect = fpage[`SECT_HI:`SECT_LO];
   wire guarded = ((wp_low | prot_en_r) & guard_r[fsect]) | frozen_r[fsect];

   // Status byte shown by the status read.
   wire [7:0] status;
   assign status[`ST_READY] = ~busy;
   assign status[`ST_WP_SEEN] = wp_seen_r;
   assign status[`ST_PROT_EN] = prot_en_r;
   assign status[`ST_BINARY] = bin_r;
   assign status[3:0] = 4'h0;

   assign busy = (timer_r != {TW{1'b0}}) | str_r | (fcnt_r != 2'h0);
   // standby when deselected; busy keeps active
   assign standby = ~framed_r & ~busy;

   // Array stream handshake; data come from the buffer register.
   assign arr_data = f0_r;
   assign arr_valid = (fcnt_r != 2'h0);
   wire pop = arr_valid & arr_ready;
   wire push = p2_r & str_r;

   // Synchronisers; pin levels reset to their idle state.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         seln_s1 <= 1'b1;
         seln_s2 <= 1'b1;
         seln_s3 <= 1'b1;
         sck_s1 <= 1'b0;
         sck_s2 <= 1'b0;
         sck_s3 <= 1'b0;
         sdi_s1 <= 1'b0;
         sdi_s2 <= 1'b0;
         wp_s1 <= 1'b1;
         wp_s2 <= 1'b1;
         rpin_s1 <= 1'b1;
         rpin_s2 <= 1'b1;
      end else begin
         seln_s1 <= select_n;
         seln_s2 <= seln_s1;
         seln_s3 <= seln_s2;
         sck_s1 <= sclk;
         sck_s2 <= sck_s1;
         sck_s3 <= sck_s2;
         sdi_s1 <= sdi;
         sdi_s2 <= sdi_s1;
         // the pull-up lives on the pad; the core sees a level
         wp_s1 <= write_protect_n;
         wp_s2 <= wp_s1;
         rpin_s1 <= reset_pin_n;
         rpin_s2 <= rpin_s1;
      end
   end

   // Buffer towards the array: push and pop may meet in one cycle.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         f0_r <= 8'h00;
         f1_r <= 8'h00;
         fcnt_r <= 2'h0;
      end else if (srst) begin
         fcnt_r <= 2'h0;
      end else begin
         case ({push, pop})
            2'b10: begin
               if (fcnt_r == 2'h0) begin
                  f0_r <= mq;
               end else begin
                  f1_r <= mq;
               end
               fcnt_r <= fcnt_r + 2'h1;
            end
            2'b01: begin
               f0_r <= f1_r;
               fcnt_r <= fcnt_r - 2'h1;
            end
            2'b11: begin
               // One leaves while one arrives, so the count stands.
               if (fcnt_r == 2'h1) begin
                  f0_r <= mq;
               end else begin
                  f0_r <= f1_r;
                  f1_r <= mq;
               end
            end
            default: begin
               fcnt_r <= fcnt_r;
            end
         endcase
      end
   end

   // Frame engine, protection state and the timed operation.
   // The pin reset aborts everything in flight but keeps protection bits.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         framed_r <= 1'b0;
         bit_r <= 3'h0;
         byte_r <= 3'h0;
         sh_r <= 7'h00;
         op_r <= 8'h00;
         addr_r <= 24'h000000;
         guard_sh_r <= 32'h00000000;
         ptr_r <= 9'h000;
         rd_phase_r <= 1'b0;
         ignore_r <= 1'b0;
         obit_r <= 3'h0;
         tx_r <= 8'h00;
         sdo <= 1'b0;
         sdo_oe <= 1'b0;
         guard_r <= 32'h00000000;
         frozen_r <= 32'h00000000;
         prot_en_r <= 1'b0;
         wp_seen_r <= 1'b0;
         bin_r <= 1'b0;
         timer_r <= {TW{1'b0}};
         str_r <= 1'b0;
         str_buf_r <= 1'b0;
         sidx_r <= 9'h000;
         sdone_r <= 1'b0;
         p1_r <= 1'b0;
         p2_r <= 1'b0;
         mwe_r <= 1'b0;
         mre_r <= 1'b0;
         mwa_r <= 10'h000;
         mra_r <= 10'h000;
         mwd_r <= 8'h00;
         arr_page <= 15'h0000;
         arr_prog_start <= 1'b0;
         arr_erase <= 1'b0;
      end else if (srst) begin
         framed_r <= 1'b0;
         bit_r <= 3'h0;
         byte_r <= 3'h0;
         rd_phase_r <= 1'b0;
         ignore_r <= 1'b0;
         sdo_oe <= 1'b0;
         timer_r <= {TW{1'b0}};
         str_r <= 1'b0;
         p1_r <= 1'b0;
         p2_r <= 1'b0;
         mwe_r <= 1'b0;
         mre_r <= 1'b0;
         arr_prog_start <= 1'b0;
         arr_erase <= 1'b0;
      end else begin
         mwe_r <= 1'b0;
         mre_r <= 1'b0;
         arr_prog_start <= 1'b0;
         arr_erase <= 1'b0;
         p1_r <= mre_r;
         p2_r <= p1_r;
         // sticky record of the protect pin
         if (wp_low) begin
            wp_seen_r <= 1'b1;
         end
         if (timer_r != {TW{1'b0}}) begin
            timer_r <= timer_r - {{(TW-1){1'b0}}, 1'b1};
         end
         // Load the fetched byte for the serial output.
         if (p2_r && !str_r) begin
            tx_r <= mq;
         end
         // Stream reads; at most two bytes in flight or buffered.
         if (str_r && !sdone_r && !mre_r && !p1_r && !p2_r && (fcnt_r != 2'h2)) begin
            mre_r <= 1'b1;
            mra_r <= {str_buf_r, sidx_r};
            sidx_r <= ptr_inc(sidx_r, bin_r);
            sdone_r <= is_last(sidx_r, bin_r);
         end
         if (str_r && sdone_r && !mre_r && !p1_r && !p2_r) begin
            str_r <= 1'b0;
         end
         // a frame opens only on a falling select edge
         if (sel_fall) begin
            framed_r <= 1'b1;
            bit_r <= 3'h0;
            byte_r <= 3'h0;
            rd_phase_r <= 1'b0;
            ignore_r <= busy;
            obit_r <= 3'h0;
         end
         // sample on rising clock; only inside a frame
         if (sel && sck_rise) begin
            sh_r <= byte_in[6:0];
            bit_r <= bit_r + 3'h1;
            if (bit_r == `BIT_LAST) begin
               if (byte_r != `BYTE_SAT) begin
                  byte_r <= byte_r + 3'h1;
               end
               // bytes assembled most significant bit first
               guard_sh_r <= {guard_sh_r[23:0], byte_in};
               if (byte_r == 3'h0) begin
                  op_r <= byte_in;
                  if (byte_in == `OP_STATUS) begin
                     rd_phase_r <= 1'b1;
                     tx_r <= status;
                  end
               end else if (byte_r <= `BYTE_ADDR_LAST) begin
                  addr_r <= {addr_r[15:0], byte_in};
                  if (byte_r == `BYTE_ADDR_LAST) begin
                     ptr_r <= byte_of({addr_r[15:0], byte_in}, bin_r);
                     // Buffer reads fetch the first byte at once.
                     if (is_rd && !ignore_r) begin
                        rd_phase_r <= 1'b1;
                        mre_r <= 1'b1;
                        mra_r <= {op_buf, byte_of({addr_r[15:0], byte_in}, bin_r)};
                     end
                  end
               end else if (!ignore_r) begin
                  // each command names one of two buffers
                  if (is_wr) begin
                     mwe_r <= 1'b1;
                     mwa_r <= {op_buf, ptr_r};
                     mwd_r <= byte_in;
                     ptr_r <= ptr_inc(ptr_r, bin_r);
                  end else if (is_rd) begin
                     mre_r <= 1'b1;
                     mra_r <= {op_buf, ptr_inc(ptr_r, bin_r)};
                     ptr_r <= ptr_inc(ptr_r, bin_r);
                  end
               end
               if (op_r == `OP_STATUS && byte_r != 3'h0) begin
                  tx_r <= status;
               end
            end
         end
         // shift out on falling clock; drive only in data phase
         if (sel && sck_fall && rd_phase_r) begin
            sdo_oe <= 1'b1;
            sdo <= tx_r[3'h7 - obit_r];
            obit_r <= obit_r + 3'h1;
         end
         // frame ends on the rising select edge
         if (sel_rise && framed_r) begin
            framed_r <= 1'b0;
            rd_phase_r <= 1'b0;
            sdo_oe <= 1'b0;
            if (!ignore_r && bit_r == 3'h0) begin
               if ((is_prog || op_r == `OP_ERASE) && byte_r >= `BYTE_DATA) begin
                  // discard while protect low; guarded sectors
                  if (!wp_low && !guarded) begin
                     arr_page <= fpage;
                     timer_r <= is_prog ? PROG_LD : ERASE_LD;
                     if (is_prog) begin
                        arr_prog_start <= 1'b1;
                        str_r <= 1'b1;
                        str_buf_r <= op_buf;
                        sidx_r <= 9'h000;
                        sdone_r <= 1'b0;
                     end else begin
                        arr_erase <= 1'b1;
                     end
                  end
               end
               if (op_r == `OP_PROT_EN) begin
                  prot_en_r <= 1'b1;
               end
               if (op_r == `OP_FREEZE && byte_r >= `BYTE_DATA) begin
                  frozen_r[fsect] <= 1'b1;
               end
               // guard writes refused after protect went low
               if (op_r == `OP_GUARD_WR && byte_r >= `BYTE_GUARD_DONE && !wp_seen_r && !wp_low) begin
                  guard_r <= guard_sh_r;
               end
               if (op_r == `OP_BINARY) begin
                  bin_r <= 1'b1;
               end
            end
         end
      end
   end

   // both page buffers in one memory
   flash_buf_ram #(
      .AW(10),
      .DW(8)
   ) u_buf (
      .clk(clk),
      .rst_b(rst_b),
      .wr_en(mwe_r),
      .wr_addr(mwa_r),
      .wr_data(mwd_r),
      .rd_en(mre_r),
      .rd_addr(mra_r),
      .rd_data(mq)
   );
endmodule // flash_pin_if

// File: sim/flash_pin_if_assertions.sv
module flash_pin_if_assertions (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Serial pins.
   input wire logic select_n,
   input wire logic sclk,
   input wire logic sdi,
   input wire logic sdo,
   input wire logic sdo_oe,
   // Protection and reset pins.
   input wire logic write_protect_n,
   input wire logic reset_pin_n,
   // Array stream and state.
   input wire logic [7:0] arr_data,
   input wire logic arr_valid,
   input wire logic arr_ready,
   input wire logic [14:0] arr_page,
   input wire logic arr_prog_start,
   input wire logic arr_erase,
   input wire logic busy,
   input wire logic standby
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Edges since the last seen serial clock fall and select rise, saturating at 15.
   logic sclk_q_r;
   logic sel_q_r;
   logic [3:0] since_fall_r;
   logic [3:0] since_rise_r;
   // Edge finders run on the core clock, as the design's synchronisers do.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sclk_q_r <= 1'b0;
         sel_q_r <= 1'b1;
         since_fall_r <= 4'hf;
         since_rise_r <= 4'hf;
      end else begin
         sclk_q_r <= sclk;
         sel_q_r <= select_n;
         since_fall_r <= (sclk_q_r && !sclk) ? 4'h0 : since_fall_r + {3'h0, since_fall_r != 4'hf};
         since_rise_r <= (!sel_q_r && select_n) ? 4'h0 : since_rise_r + {3'h0, since_rise_r != 4'hf};
      end
   end
   // A stall with the reset pin high long enough that its synchroniser cannot act.
   sequence stall_s;
      arr_valid && !arr_ready && reset_pin_n && $past(reset_pin_n) && $past(reset_pin_n, 2) && $past(reset_pin_n, 3);
   endsequence
   sequence pin_reset_held_s;
      !reset_pin_n [*5];
   endsequence
   sequence deselected_s;
      select_n [*5];
   endsequence
   a_oe_off_deselected: assert property (deselected_s |-> !sdo_oe)
      else $error("serial output driven while deselected");
   a_oe_rise_fall: assert property ($rose(sdo_oe) |-> since_fall_r <= 4'h7)
      else $error("serial output enabled away from a clock fall");
   a_sdo_on_fall: assert property (sdo_oe && $changed(sdo) |-> since_fall_r <= 4'h7)
      else $error("serial output changed away from a clock fall");
   a_act_on_deselect: assert property (arr_prog_start || arr_erase |-> since_rise_r <= 4'h7)
      else $error("array action started without a select rise");
   a_prog_needs_wp: assert property (arr_prog_start |-> write_protect_n && $past(write_protect_n, 8))
      else $error("program started with protect pin low");
   a_prog_then_busy: assert property (arr_prog_start |=> busy [*3])
      else $error("busy not held after program start");
   a_standby_not_busy: assert property (standby |-> !busy)
      else $error("standby while busy");
   a_stall_holds: assert property (stall_s |=> arr_valid && $stable(arr_data))
      else $error("stream word lost during stall");
   a_pin_reset_idle: assert property (pin_reset_held_s |-> !busy && !sdo_oe && !arr_valid)
      else $error("reset pin low but device active");
   a_valid_busy: assert property (arr_valid |-> busy && !standby)
      else $error("stream word present while idle");
endmodule // flash_pin_if_assertions

// File: sim/spi_host_model.sv
// Host side of the serial link; the core clock only paces its serial clock.
module spi_host_model (
   // Pacing clock.
   input wire logic clk,
   // Serial pins toward the device.
   output logic select_n,
   output logic sclk,
   output logic sdi,
   input wire logic sdo
);
   timeunit 1ns;
   timeprecision 1ps;
   // Half of the 64 ns serial period in core clocks.
   localparam int HALF = 8;
   logic mode3_r = 1'b0;
   initial begin
      select_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end
   // All changes land at falling core edges, away from the device's sampling.
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic open_frame(input logic mode3);
      mode3_r = mode3;
      sclk = mode3;
      wait_clk(HALF);
      select_n = 1'b0;
      wait_clk(HALF);
   endtask
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sclk = 1'b0;
         sdi = tx[i];
         wait_clk(HALF);
         sclk = 1'b1;
         rx[i] = sdo;
         wait_clk(HALF);
      end
   endtask
   // Closing restores the idle level, so mode 0 ends with one more fall.
   task automatic close_frame();
      sclk = mode3_r;
      wait_clk(HALF);
      select_n = 1'b1;
      // Released data line shows the inverse, never a stale bit.
      sdi = ~sdi;
      wait_clk(2 * HALF);
   endtask
   // Clocks bits while deselected; only a scenario about ignored input calls it.
   task automatic noise(input logic [7:0] tx);
      for (int i = 7; i >= 0; i--) begin
         sdi = tx[i];
         sclk = 1'b0;
         wait_clk(HALF);
         sclk = 1'b1;
         wait_clk(HALF);
      end
      sclk = 1'b0;
   endtask
endmodule // spi_host_model

// File: sim/flash_pin_if_test.sv
module flash_pin_if_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_b, select_n, sclk, sdi, sdo, sdo_oe, write_protect_n, reset_pin_n;
   logic [7:0] arr_data;
   logic arr_valid, arr_ready, arr_prog_start, arr_erase, busy, standby;
   logic [14:0] arr_page;
   logic [7:0] rx;
   logic prog_seen_r = 1'b0;
   logic erase_seen_r = 1'b0;
   // A released output reads as the inverse of its last bit, so a stale sample shows up.
   wire sdo_line = sdo_oe ? sdo : ~sdo;
   int num_errors = 0;
   int comparisons = 0;
   // 250 MHz core clock.
   always #2 clk = ~clk;
   // Remembers any program start; scenarios clear it at a falling edge.
   always @(posedge clk) if (arr_prog_start === 1'b1) prog_seen_r <= 1'b1;
   // Remembers any erase start in the same way.
   always @(posedge clk) if (arr_erase === 1'b1) erase_seen_r <= 1'b1;
   // Short program timer; erase keeps its full length and is only ever aborted.
   flash_pin_if #(.PROG_CYCLES(50)) flash_pin_if_i (.clk(clk), .rst_b(rst_b),
      .select_n(select_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .write_protect_n(write_protect_n),
      .reset_pin_n(reset_pin_n), .arr_data(arr_data), .arr_valid(arr_valid), .arr_ready(arr_ready),
      .arr_page(arr_page), .arr_prog_start(arr_prog_start), .arr_erase(arr_erase), .busy(busy), .standby(standby));
   spi_host_model spi_host_model_i (.clk(clk), .select_n(select_n), .sclk(sclk), .sdi(sdi), .sdo(sdo_line));
   task automatic wrap_up();
      if (num_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Bounded wait for the device to settle back to standby.
   task automatic wait_standby(input int limit);
      int n;
      n = 0;
      while (standby !== 1'b1) begin
         @(negedge clk);
         n++;
         if (n > limit) begin
            num_errors++;
            $display("BAD standby expected 1 seen %b", standby);
            wrap_up();
         end
      end
   endtask
   // Opcode then three address bytes; the frame is left open.
   task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic mode3);
      spi_host_model_i.open_frame(mode3);
      spi_host_model_i.xfer(op, rx);
      spi_host_model_i.xfer(a[23:16], rx);
      spi_host_model_i.xfer(a[15:8], rx);
      spi_host_model_i.xfer(a[7:0], rx);
   endtask
   task automatic t_reset_state();
      check("standby", 16'h1, 16'(standby));
      check("sdo_oe", 16'h0, 16'(sdo_oe));
   endtask
   // Both buffers written in different modes, then read back crosswise.
   task automatic t_buffers();
      cmd(8'h10, 24'h0, 1'b0);
      spi_host_model_i.xfer(8'ha5, rx);
      spi_host_model_i.xfer(8'h3c, rx);
      spi_host_model_i.close_frame();
      cmd(8'h11, 24'h0, 1'b1);
      spi_host_model_i.xfer(8'h77, rx);
      spi_host_model_i.close_frame();
      cmd(8'h20, 24'h0, 1'b1);
      spi_host_model_i.xfer(8'h00, rx);
      check("buffer1 byte0", 16'ha5, 16'(rx));
      spi_host_model_i.xfer(8'h00, rx);
      check("buffer1 byte1", 16'h3c, 16'(rx));
      spi_host_model_i.close_frame();
      cmd(8'h21, 24'h0, 1'b0);
      spi_host_model_i.xfer(8'h00, rx);
      check("buffer2 byte0", 16'h77, 16'(rx));
      spi_host_model_i.close_frame();
      check("sdo_oe", 16'h0, 16'(sdo_oe));
   endtask
   // Program page 5 with the array stalled, then drain with a toggling ready.
   task automatic t_program();
      int pops;
      pops = 0;
      arr_ready = 1'b0;
      prog_seen_r = 1'b0;
      cmd(8'h30, {15'h5, 9'h0}, 1'b0);
      spi_host_model_i.close_frame();
      check("prog start", 16'h1, 16'(prog_seen_r));
      check("arr_page", 16'h5, 16'(arr_page));
      repeat (20) @(negedge clk);
      check("stalled head", 16'ha5, 16'(arr_data));
      for (int c = 0; c < 1500; c++) begin
         @(negedge clk);
         arr_ready = c[0];
         if (arr_valid === 1'b1 && arr_ready === 1'b1) begin
            if (pops == 1) check("second byte", 16'h3c, 16'(arr_data));
            pops++;
         end
      end
      check("page bytes", 16'd264, 16'(pops));
      wait_standby(300);
   endtask
   // Protect pin low: program dropped, protection enable still taken.
   task automatic t_protect();
      write_protect_n = 1'b0;
      prog_seen_r = 1'b0;
      cmd(8'h30, {15'h5, 9'h0}, 1'b0);
      spi_host_model_i.close_frame();
      repeat (100) @(negedge clk);
      check("prog dropped", 16'h0, 16'(prog_seen_r));
      check("standby", 16'h1, 16'(standby));
      spi_host_model_i.open_frame(1'b0);
      spi_host_model_i.xfer(8'h60, rx);
      spi_host_model_i.close_frame();
      spi_host_model_i.open_frame(1'b1);
      spi_host_model_i.xfer(8'h50, rx);
      spi_host_model_i.xfer(8'h00, rx);
      spi_host_model_i.close_frame();
      check("status", 16'he, 16'(rx[7:4]));
      write_protect_n = 1'b1;
   endtask
   // Guard write refused after the protect pin was low, so erase and program
   // still start; the reset pin then aborts each and returns to idle.
   task automatic t_reset_pin();
      spi_host_model_i.open_frame(1'b0);
      spi_host_model_i.xfer(8'h62, rx);
      repeat (4) spi_host_model_i.xfer(8'hff, rx);
      spi_host_model_i.close_frame();
      for (int k = 0; k < 2; k++) begin
         arr_ready = 1'b0;
         prog_seen_r = 1'b0;
         erase_seen_r = 1'b0;
         cmd(k ? 8'h30 : 8'h40, {15'h9, 9'h0}, k[0]);
         spi_host_model_i.close_frame();
         check("action start", 16'h1, 16'(k ? prog_seen_r : erase_seen_r));
         reset_pin_n = 1'b0;
         repeat (8) @(negedge clk);
         check("busy", 16'h0, 16'(busy));
         check("arr_valid", 16'h0, 16'(arr_valid));
         reset_pin_n = 1'b1;
         arr_ready = 1'b1;
         repeat (8) @(negedge clk);
         check("standby", 16'h1, 16'(standby));
      end
   endtask
   // A program opcode clocked in while deselected must do nothing.
   task automatic t_noise();
      prog_seen_r = 1'b0;
      spi_host_model_i.noise(8'h30);
      spi_host_model_i.noise(8'h00);
      repeat (40) @(negedge clk);
      check("ignored input", 16'h0, 16'(prog_seen_r));
      check("sdo_oe", 16'h0, 16'(sdo_oe));
   endtask
   initial begin
      rst_b = 1'b0;
      write_protect_n = 1'b1;
      reset_pin_n = 1'b1;
      arr_ready = 1'b0;
      repeat (16) @(negedge clk);
      rst_b = 1'b1;
      repeat (8) @(negedge clk);
      t_reset_state();
      t_buffers();
      t_program();
      t_protect();
      t_reset_pin();
      t_noise();
      wrap_up();
   end
   // Hang guard well beyond the length of the whole run.
   initial begin
      #400000;
      num_errors++;
      $display("BAD run expected end seen timeout");
      wrap_up();
   end
endmodule // flash_pin_if_test
bind flash_pin_if flash_pin_if_assertions chk_i (
   .clk(clk), .rst_b(rst_b), .select_n(select_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
   .write_protect_n(write_protect_n), .reset_pin_n(reset_pin_n), .arr_data(arr_data), .arr_valid(arr_valid),
   .arr_ready(arr_ready), .arr_page(arr_page), .arr_prog_start(arr_prog_start), .arr_erase(arr_erase),
   .busy(busy), .standby(standby));
